// file: sim/tb_top.sv
// Self-checking bench for the trace-control and register-move executor.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic clk_sys, rstn, req_valid, req_src1_lit, req_src2_lit, done_q, fault_q;
	logic fetch_nonbranch, exec_nonbranch, wr_en;
	logic [2:0] req_op;
	logic [4:0] req_src1, req_src2, req_dst, wr_addr, rd_addr;
	logic [31:0] wr_data, rd_data_q, trace_controls, trace_control_register, trc_exp, trc_old;
	logic [31:0] regs [32];
	logic [31:0] seed = 32'h00000054;
	logic fq [$];
	int num_errors = 0;
	int n_compared = 0;
	trace_move_exec i_dut (.clk_sys(clk_sys), .rstn(rstn), .req_valid(req_valid),
		.req_op(req_op), .req_src1_lit(req_src1_lit), .req_src1(req_src1),
		.req_src2_lit(req_src2_lit), .req_src2(req_src2), .req_dst(req_dst),
		.done_q(done_q), .fault_q(fault_q), .fetch_nonbranch(fetch_nonbranch),
		.exec_nonbranch(exec_nonbranch), .trace_controls(trace_controls), .wr_en(wr_en),
		.wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr), .rd_data_q(rd_data_q),
		.trace_control_register(trace_control_register));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic tally_and_finish();
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : tally_and_finish
	task automatic ins(input logic [2:0] op, input logic l1, input logic [4:0] s1,
		input logic l2, input logic [4:0] s2, input logic [4:0] d, input logic f);
		@(negedge clk_sys);
		req_valid = 1'b1;
		req_op = op;
		req_src1_lit = l1;
		req_src1 = s1;
		req_src2_lit = l2;
		req_src2 = s2;
		req_dst = d;
		fq.push_back(f);
	endtask : ins
	task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
		@(negedge clk_sys);
		req_valid = 1'b0;
		rd_addr = a;
		@(negedge clk_sys);
		chk(rd_data_q, e);
	endtask : rd_chk
	// Shadow copy is built from old values first, matching the exact-copy overlap choice.
	task automatic mv(input logic [2:0] op, input logic lit, input logic [4:0] s, input logic [4:0] d);
		logic [31:0] t [4];
		int n;
		logic bad;
		n = int'(op);
		bad = (n == 2 && (d[0] || (!lit && s[0]))) || (n > 2 && (d[1:0] != 0 || (!lit && s[1:0] != 0)));
		for (int k = 0; k < n; k++)
			t[k] = lit ? ((k == 0) ? {27'h0, s} : 32'h0) : regs[5'(s + k)];
		if (!bad)
			for (int k = 0; k < n; k++)
				regs[5'(d + k)] = t[k];
		ins(op, lit, s, 1'b0, 5'h0, d, bad);
		for (int k = 0; k < n; k++)
			rd_chk(5'(d + k), regs[5'(d + k)]);
	endtask : mv
	task automatic mt(input logic l1, input logic [4:0] s1, input logic l2, input logic [4:0] s2,
		input logic [4:0] d);
		logic [31:0] m, e, v;
		m = l1 ? {27'h0, s1} : regs[s1];
		v = l2 ? {27'h0, s2} : regs[s2];
		e = (trace_move_pkg::TRACE_EVENT_FLAGS & trc_exp & m)
			| (trace_move_pkg::TRACE_MODE_BITS & m);
		trc_old = trc_exp;
		ins(trace_move_pkg::OP_MODTC, l1, s1, l2, s2, d, 1'b0);
		trc_exp = (e & v) | (trc_exp & ~e);
		regs[d] = trc_old;
		@(negedge clk_sys);
		req_valid = 1'b0;
		chk(trace_control_register, trc_exp);
		rd_chk(d, regs[d]);
	endtask : mt
	initial
	begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	initial
	forever
	begin
		@(posedge clk_sys);
		#1;
		if (done_q === 1'b1)
			chk(32'(fault_q), fq.size() > 0 ? 32'(fq.pop_front()) : 32'hX);
	end
	initial
	begin
		repeat (3000) @(posedge clk_sys);
		num_errors++;
		tally_and_finish();
	end
	initial
	begin
		{rstn, req_valid, req_src1_lit, req_src2_lit, fetch_nonbranch, exec_nonbranch, wr_en} = '0;
		{req_op, req_src1, req_src2, req_dst, wr_addr, rd_addr, wr_data} = '0;
		trc_exp = trace_move_pkg::TRACE_RESET;
		repeat (20) @(negedge clk_sys);
		rstn = 1'b1;
		rd_chk(5'h05, trace_move_pkg::REG_RESET);
		for (int i = 0; i < 32; i++)
		begin
			@(negedge clk_sys);
			wr_en = 1'b1;
			wr_addr = 5'(i);
			wr_data = rnd() & (i == 1 ? trace_move_pkg::TRACE_MODE_BITS
				| trace_move_pkg::TRACE_EVENT_FLAGS : 32'hFFFFFFFF);
			regs[i] = wr_data;
		end
		@(negedge clk_sys);
		wr_en = 1'b0;
		for (int op = 1; op <= 4; op++)
		begin
			mv(3'(op), 1'b0, 5'(rnd()) & ~5'(op == 1 ? 0 : op == 2 ? 1 : 3),
				5'h10 + 5'(4 * op - 4));
			mv(3'(op), 1'b1, 5'(rnd()), 5'h08);
		end
		mv(3'h2, 1'b0, 5'h03, 5'h08);
		mv(3'h4, 1'b0, 5'h04, 5'h06);
		mt(1'b0, 5'h01, 1'b0, 5'h02, 5'h03);
		for (int i = 1; i <= 4; i++)
		begin
			@(negedge clk_sys);
			exec_nonbranch = 1'b1;
			if (i == 4)
				chk(trace_controls, trc_old);
		end
		@(negedge clk_sys);
		exec_nonbranch = 1'b0;
		chk(trace_controls, trc_exp);
		mt(1'b1, 5'h1E, 1'b1, 5'h16, 5'h0C);
		@(negedge clk_sys);
		fetch_nonbranch = 1'b1;
		chk(trace_controls, trc_old);
		@(negedge clk_sys);
		fetch_nonbranch = 1'b0;
		chk(trace_controls, trc_exp);
		chk(32'(fq.size()), 32'h0);
		tally_and_finish();
	end
endmodule : tb_top
`default_nettype wire

// file: verilog/trace_mod_unit.sv
// Masked update of the trace control register value.
`timescale 1ns/10ps
`default_nettype none
module trace_mod_unit
(
	// Present register value and operands
	input wire logic [31:0] trace_cur,
	input wire logic [31:0] mask,
	input wire logic [31:0] src2,
	// Result
	output logic [31:0] eff_mask,
	output logic [31:0] trace_new
);
	// Event flags can only be written while set, so software can clear but never raise them.
	assign eff_mask = (trace_move_pkg::TRACE_EVENT_FLAGS & trace_cur & mask)
		| (trace_move_pkg::TRACE_MODE_BITS & mask);
	assign trace_new = (eff_mask & src2) | (trace_cur & ~eff_mask);
endmodule : trace_mod_unit
`default_nettype wire

// file: verilog/trace_move_exec.sv
// Executor for the trace-control modify instruction and the register move family.
`timescale 1ns/10ps
`default_nettype none
module trace_move_exec
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// Instruction request, one per cycle
	input wire logic req_valid,
	input wire logic [2:0] req_op,
	input wire logic req_src1_lit,
	input wire logic [4:0] req_src1,
	input wire logic req_src2_lit,
	input wire logic [4:0] req_src2,
	input wire logic [4:0] req_dst,
	// Completion
	output logic done_q,
	output logic fault_q,
	// Pipeline events that end a pending trace update
	input wire logic fetch_nonbranch,
	input wire logic exec_nonbranch,
	// Trace controls in force
	output logic [31:0] trace_controls,
	// Register file side port and architectural trace control value
	input wire logic wr_en,
	input wire logic [4:0] wr_addr,
	input wire logic [31:0] wr_data,
	input wire logic [4:0] rd_addr,
	output logic [31:0] rd_data_q,
	output logic [31:0] trace_control_register
);
	logic [31:0] regs_q [trace_move_pkg::NUM_REGS];
	logic [31:0] trace_ctrl_q;
	logic [31:0] trace_active_q;
	logic trace_pending_q;
	logic [2:0] exec_cnt_q;
	logic [2:0] exec_cnt_d;

	function automatic logic [31:0] operand(input logic is_lit, input logic [4:0] v,
		input logic [31:0] rv);
		operand = is_lit ? {27'h0000000, v} : rv;
	endfunction : operand

	// Decode.
	wire is_modtc = req_valid && (req_op == trace_move_pkg::OP_MODTC);
	wire is_move = req_valid && (req_op >= trace_move_pkg::OP_MOV)
		&& (req_op <= trace_move_pkg::OP_MOVQ);
	wire [2:0] move_cnt = req_op;
	wire need_pair = (req_op == trace_move_pkg::OP_MOVL);
	wire need_quad = (req_op == trace_move_pkg::OP_MOVT) || (req_op == trace_move_pkg::OP_MOVQ);
	// A literal source has no register number, so only the destination is checked then.
	wire src_bad = !req_src1_lit && ((need_pair && req_src1[0]) || (need_quad && req_src1[1:0] != 2'h0));
	wire dst_bad = (need_pair && req_dst[0]) || (need_quad && req_dst[1:0] != 2'h0);
	wire misaligned = is_move && (src_bad || dst_bad);
	wire move_go = is_move && !misaligned;

	// Modify operands and result.
	wire [31:0] mask_val = operand(req_src1_lit, req_src1, regs_q[req_src1]);
	wire [31:0] src2_val = operand(req_src2_lit, req_src2, regs_q[req_src2]);
	wire [31:0] trace_new;
	wire [31:0] trace_eff_mask;

	trace_mod_unit u_mod
	(
		.trace_cur(trace_ctrl_q),
		.mask(mask_val),
		.src2(src2_val),
		.eff_mask(trace_eff_mask),
		.trace_new(trace_new)
	);

	// Move lanes: every source is read from the old file, so overlap still gives a copy.
	wire [4:0] lane_addr [trace_move_pkg::MAX_MOVE];
	wire [31:0] lane_data [trace_move_pkg::MAX_MOVE];
	wire lane_en [trace_move_pkg::MAX_MOVE];
	genvar k;
	generate
		for (k = 0; k < 4; k++)
		begin : g_lane
			wire [4:0] src_addr = req_src1 + 5'(k);
			assign lane_addr[k] = req_dst + 5'(k);
			assign lane_en[k] = move_go && (3'(k) < move_cnt);
			if (k == 0)
			begin : g_first
				assign lane_data[k] = operand(req_src1_lit, req_src1, regs_q[src_addr]);
			end
			else
			begin : g_rest
				assign lane_data[k] = req_src1_lit ? 32'h00000000 : regs_q[src_addr];
			end
		end
	endgenerate

	// Register file; instruction results win over the side write port.
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			for (int i = 0; i < 32; i++)
				regs_q[i] <= trace_move_pkg::REG_RESET;
		end
		else
		begin
			if (wr_en)
				regs_q[wr_addr] <= wr_data;
			for (int i = 0; i < 4; i++)
				if (lane_en[i])
					regs_q[lane_addr[i]] <= lane_data[i];
			if (is_modtc)
				regs_q[req_dst] <= trace_ctrl_q;
		end
	end

	// A misaligned move writes nothing; the destinations keep their previous contents.
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			done_q <= 1'b0;
			fault_q <= 1'b0;
			rd_data_q <= 32'h00000000;
		end
		else
		begin
			done_q <= is_modtc || is_move;
			fault_q <= misaligned;
			rd_data_q <= regs_q[rd_addr];
		end
	end

	// Trace controls: architectural value changes at once, the value in force follows later.
	wire cnt_full = (exec_cnt_q + 3'(exec_nonbranch)) >= trace_move_pkg::DELAY_EXEC_COUNT;
	wire apply_now = trace_pending_q && (fetch_nonbranch || cnt_full || is_modtc);
	assign exec_cnt_d = is_modtc ? 3'h0 : (trace_pending_q ? exec_cnt_q + 3'(exec_nonbranch) : 3'h0);

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			trace_ctrl_q <= trace_move_pkg::TRACE_RESET;
			trace_active_q <= trace_move_pkg::TRACE_RESET;
			trace_pending_q <= 1'b0;
			exec_cnt_q <= 3'h0;
		end
		else
		begin
			if (is_modtc)
				trace_ctrl_q <= trace_new;
			if (apply_now)
				trace_active_q <= trace_ctrl_q;
			trace_pending_q <= is_modtc || (trace_pending_q && !apply_now);
			exec_cnt_q <= exec_cnt_d;
		end
	end

	assign trace_controls = trace_active_q;
	assign trace_control_register = trace_ctrl_q;

	// Checks.
	a_trace_old_dst: assert property (@(posedge clk_sys) disable iff (!rstn)
		is_modtc |=> regs_q[$past(req_dst)] == $past(trace_ctrl_q))
		else $error("destination did not receive old trace value");
	a_trace_mask_keep: assert property (@(posedge clk_sys) disable iff (!rstn)
		is_modtc |=> ((trace_ctrl_q ^ $past(trace_ctrl_q)) & ~$past(trace_eff_mask)) == 32'h00000000)
		else $error("unmasked trace bit changed");
	a_trace_reserved_keep: assert property (@(posedge clk_sys) disable iff (!rstn)
		is_modtc |=> ((trace_ctrl_q ^ $past(trace_ctrl_q)) & ~trace_move_pkg::TRACE_MODE_BITS
		& ~trace_move_pkg::TRACE_EVENT_FLAGS) == 32'h00000000)
		else $error("reserved trace bit changed");
	a_trace_write_val: assert property (@(posedge clk_sys) disable iff (!rstn)
		is_modtc |=> (trace_ctrl_q & $past(trace_eff_mask)) == ($past(src2_val) & $past(trace_eff_mask)))
		else $error("selected trace bits not taken from operand");
	a_trace_delay_bound: assert property (@(posedge clk_sys) disable iff (!rstn)
		(trace_pending_q && fetch_nonbranch) |=> trace_controls == $past(trace_ctrl_q))
		else $error("trace update not in force after fetch");
	a_trace_count_apply: assert property (@(posedge clk_sys) disable iff (!rstn)
		(trace_pending_q && cnt_full) |=> trace_controls == $past(trace_ctrl_q))
		else $error("trace update not in force after four executions");
	a_trace_count_cap: assert property (@(posedge clk_sys) disable iff (!rstn)
		trace_pending_q |-> exec_cnt_q < trace_move_pkg::DELAY_EXEC_COUNT)
		else $error("trace update pending past four executions");
	a_quad_src_fault: assert property (@(posedge clk_sys) disable iff (!rstn)
		(is_move && req_op == trace_move_pkg::OP_MOVQ && !req_src1_lit
		&& req_src1[1:0] != 2'h0) |=> fault_q && done_q)
		else $error("misaligned quad source raised no fault");
	a_fault_keeps_dst: assert property (@(posedge clk_sys) disable iff (!rstn)
		(misaligned && !wr_en) |=> regs_q[$past(req_dst)] == $past(regs_q[req_dst]))
		else $error("faulting move wrote its destination");
	a_move_lit_first: assert property (@(posedge clk_sys) disable iff (!rstn)
		(move_go && req_src1_lit) |=> regs_q[$past(req_dst)] == {27'h0000000, $past(req_src1)})
		else $error("literal not placed in first destination");
	a_move_fault: assert property (@(posedge clk_sys) disable iff (!rstn)
		(is_move && req_op == trace_move_pkg::OP_MOVL && req_dst[0]) |=> fault_q && done_q)
		else $error("misaligned pair move raised no fault");
	a_move_lit_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
		(move_go && req_src1_lit && req_op == trace_move_pkg::OP_MOVQ && !wr_en)
		|=> regs_q[$past(req_dst)] == {27'h0000000, $past(req_src1)}
		&& regs_q[$past(req_dst) + 5'h3] == 32'h00000000)
		else $error("literal move not zero-extended");
	a_move_copy: assert property (@(posedge clk_sys) disable iff (!rstn)
		(move_go && !req_src1_lit && req_op == trace_move_pkg::OP_MOVL && !wr_en)
		|=> regs_q[$past(req_dst) + 5'h1] == $past(regs_q[req_src1 + 5'h1]) && !fault_q)
		else $error("second register of pair move wrong");
	a_move_align_ok: assert property (@(posedge clk_sys) disable iff (!rstn)
		(is_move && req_op == trace_move_pkg::OP_MOV) |=> !fault_q)
		else $error("single move faulted");
	c_modtc: cover property (@(posedge clk_sys) disable iff (!rstn) is_modtc && trace_eff_mask != 32'h0);
	c_delay_four: cover property (@(posedge clk_sys) disable iff (!rstn)
		trace_pending_q && cnt_full && !fetch_nonbranch);
	c_movq_reg: cover property (@(posedge clk_sys) disable iff (!rstn) move_go && move_cnt == 3'h4);
	c_fault: cover property (@(posedge clk_sys) disable iff (!rstn) misaligned);
endmodule : trace_move_exec
`default_nettype wire

// file: verilog/trace_move_pkg.sv
// Constants shared by the trace-control and register-move executor.
package trace_move_pkg;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned NUM_REGS = 32;
	localparam int unsigned REG_AW = 5;
	localparam int unsigned LIT_W = 5;
	localparam int unsigned MAX_MOVE = 4;
	localparam logic [31:0] TRACE_MODE_BITS = 32'h000000FE;
	localparam logic [31:0] TRACE_EVENT_FLAGS = 32'h0F000000;
	localparam logic [31:0] TRACE_RESET = 32'h00000000;
	localparam logic [31:0] REG_RESET = 32'h00000000;
	localparam logic [2:0] DELAY_EXEC_COUNT = 3'h4;
	localparam logic [2:0] OP_MODTC = 3'h0;
	localparam logic [2:0] OP_MOV = 3'h1;
	localparam logic [2:0] OP_MOVL = 3'h2;
	localparam logic [2:0] OP_MOVT = 3'h3;
	localparam logic [2:0] OP_MOVQ = 3'h4;
endpackage : trace_move_pkg
